// ### logic/gpio_pkg.sv
// Constants shared by the general purpose port block.
package gpio_pkg;

	// Bus geometry.
	localparam int          ADDR_W        = 5;
	localparam int          DATA_W        = 32;
	localparam int          ADDR_LSB      = 2;

	// Port geometry.
	localparam int          NUM_BIDIR     = 3;
	localparam int          PORT_W        = 8;
	localparam int          IN_PORT_W     = 7;

	// Register indices; the byte address is four times the index.
	localparam logic [2:0]  IDX_DATA0     = 3'h0;
	localparam logic [2:0]  IDX_DATA1     = 3'h1;
	localparam logic [2:0]  IDX_DATA2     = 3'h2;
	localparam logic [2:0]  IDX_IN_DATA   = 3'h3;
	localparam logic [2:0]  IDX_DIR0      = 3'h4;
	localparam logic [2:0]  IDX_DIR1      = 3'h5;
	localparam logic [2:0]  IDX_DIR2      = 3'h6;

	// Values after reset.
	localparam logic [7:0]  DIR_RESET     = 8'h00;
	localparam logic        LINE_IDLE     = 1'b1;

	// Bus response codes.
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ### logic/ext_irq_latch.sv
// External interrupt request latch with edge or edge-and-level sensing.
`timescale 1ns/100ps
module ext_irq_latch (
	// Clock, reset and enable.
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// Combined active low interrupt line and its sensing mode.
	input  wire logic line_n,
	input  wire logic level_mode,
	// Service side.
	input  wire logic ack,
	output logic      req
);
	import gpio_pkg::*;

	logic line_prev_reg;
	logic pend_reg;
	logic pend_next;
	logic sync1_reg;
	logic sync2_reg;
	logic fall;
	logic set_req;

	assign fall    = line_prev_reg & ~line_n;
	// Level mode keeps requesting for as long as the line stays low.
	assign set_req = fall | (level_mode & ~line_n);
	// A new request in the acknowledge cycle is kept, not lost.
	assign pend_next = set_req | (pend_reg & ~ack);
	assign req       = sync2_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_prev_reg <= LINE_IDLE;
			pend_reg      <= 1'b0;
			sync1_reg     <= 1'b0;
			sync2_reg     <= 1'b0;
		end else if (ce) begin
			line_prev_reg <= line_n;
			pend_reg      <= pend_next; // RQ19
			sync1_reg     <= pend_reg; // RQ19
			sync2_reg     <= sync1_reg;
		end
	end

	property p_fall_reaches_req;
		@(posedge clk) disable iff (rst)
		(ce && fall && !ack) ##1 ce [*3] |-> req;
	endproperty
	a_fall_reaches_req: assert property (p_fall_reaches_req) // RQ19
		else $error("Falling edge did not raise the request.");

endmodule // ext_irq_latch

// ### logic/gpio_ports.sv
// General purpose port block: three bidirectional ports and one input port.
//
// Function
// (RQ1) Three eight-bit bidirectional ports, per-pin direction.
// (RQ2) Direction one drives pin, zero is input.
// (RQ3) Reset clears every direction register.
// (RQ4) Reset leaves port data latches unchanged.
// (RQ5) Input pin write updates latch only.
// (RQ6) Output pin write updates latch and pin.
// (RQ7) Input bits read back live pin level.
// (RQ8) Output bits read back the latch.
// (RQ9) Direction registers are readable and writable.
// (RQ10) First port at index zero and four.
// (RQ11) Second port at index one and five.
// (RQ12) Third port at index two and six.
// (RQ13) Seven-pin input port, serial drivers may override.
// (RQ14) Reset disables special drivers on input port.
// (RQ15) Option gives second port interrupt and pullup.
// (RQ16) Second port shares external interrupt sensitivity.
// (RQ17) Software writes latch before setting direction.
// (RQ18) Software presets latch before output-to-input switch.
// (RQ19) Falling edge latched, then synchronised internally.
// (RQ20) Input port register read-only, top bit zero.
`timescale 1ns/100ps
module gpio_ports #(
	parameter logic [7:0] PULLUP_IRQ_OPT = 8'h00,
	parameter logic       EDGE_LEVEL_OPT = 1'b0
) (
	// Clock, reset and enable.
	input  wire logic                       CORE_CLK,
	input  wire logic                       RST,
	input  wire logic                       CE,
	// Write address channel.
	input  wire logic [gpio_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                       S_AXI_AWVALID,
	output logic                            S_AXI_AWREADY,
	// Write data channel.
	input  wire logic [gpio_pkg::DATA_W-1:0] S_AXI_WDATA,
	input  wire logic [3:0]                 S_AXI_WSTRB,
	input  wire logic                       S_AXI_WVALID,
	output logic                            S_AXI_WREADY,
	// Write response channel.
	output logic [1:0]                      S_AXI_BRESP,
	output logic                            S_AXI_BVALID,
	input  wire logic                       S_AXI_BREADY,
	// Read address channel.
	input  wire logic [gpio_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                       S_AXI_ARVALID,
	output logic                            S_AXI_ARREADY,
	// Read data channel.
	output logic [gpio_pkg::DATA_W-1:0]     S_AXI_RDATA,
	output logic [1:0]                      S_AXI_RRESP,
	output logic                            S_AXI_RVALID,
	input  wire logic                       S_AXI_RREADY,
	// First bidirectional port pins.
	input  wire logic [gpio_pkg::PORT_W-1:0] P0_IN,
	output logic [gpio_pkg::PORT_W-1:0]     P0_OUT,
	output logic [gpio_pkg::PORT_W-1:0]     P0_OE,
	// Second bidirectional port pins and pullup controls.
	input  wire logic [gpio_pkg::PORT_W-1:0] P1_IN,
	output logic [gpio_pkg::PORT_W-1:0]     P1_OUT,
	output logic [gpio_pkg::PORT_W-1:0]     P1_OE,
	output logic [gpio_pkg::PORT_W-1:0]     P1_PULLUP,
	// Third bidirectional port pins.
	input  wire logic [gpio_pkg::PORT_W-1:0] P2_IN,
	output logic [gpio_pkg::PORT_W-1:0]     P2_OUT,
	output logic [gpio_pkg::PORT_W-1:0]     P2_OE,
	// Input-only port pins and serial special function drivers.
	input  wire logic [gpio_pkg::IN_PORT_W-1:0] IN_PINS,
	input  wire logic [gpio_pkg::IN_PORT_W-1:0] SF_OUT,
	input  wire logic [gpio_pkg::IN_PORT_W-1:0] SF_OE,
	output logic [gpio_pkg::IN_PORT_W-1:0]  IN_OUT,
	output logic [gpio_pkg::IN_PORT_W-1:0]  IN_OE,
	// External interrupt.
	input  wire logic                       IRQ_N,
	input  wire logic                       IRQ_ACK,
	output logic                            IRQ_REQ
);
	import gpio_pkg::*;

	// Register index decode, shared by the write and read paths.
	function automatic logic [2:0] idx_of(input logic [ADDR_W-1:0] a);
		idx_of = a[ADDR_W-1:ADDR_LSB];
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [2:0] i;
		i = a[ADDR_W-1:ADDR_LSB];
		mapped = (i <= IDX_DIR2);
	endfunction

	logic [PORT_W-1:0]  latch_reg [NUM_BIDIR];
	logic [PORT_W-1:0]  dir_reg   [NUM_BIDIR];
	logic [PORT_W-1:0]  pin_in    [NUM_BIDIR];
	logic [PORT_W-1:0]  rd_val    [NUM_BIDIR];

	logic               aw_held_reg;
	logic [ADDR_W-1:0]  aw_addr_reg;
	logic               w_held_reg;
	logic [7:0]         w_data_reg;
	logic               w_lane0_reg;
	logic               bvalid_reg;
	logic [1:0]         bresp_reg;
	logic               rvalid_reg;
	logic [DATA_W-1:0]  rdata_reg;
	logic [1:0]         rresp_reg;

	wire                aw_take  = S_AXI_AWVALID & S_AXI_AWREADY;
	wire                w_take   = S_AXI_WVALID & S_AXI_WREADY;
	wire                ar_take  = S_AXI_ARVALID & S_AXI_ARREADY;
	wire                do_write = CE & aw_held_reg & w_held_reg & ~bvalid_reg;
	wire [2:0]          wr_idx   = idx_of(aw_addr_reg);
	wire                wr_ok    = mapped(aw_addr_reg);
	wire [2:0]          rd_idx   = idx_of(S_AXI_ARADDR);
	wire                rd_ok    = mapped(S_AXI_ARADDR);
	wire [7:0]          in_val   = {1'b0, IN_PINS};
	wire                irq_line_n;
	logic [7:0]         rd_byte;

	assign pin_in[0] = P0_IN;
	assign pin_in[1] = P1_IN;
	assign pin_in[2] = P2_IN;

	// Handshakes drop while the block is frozen, so nothing is taken and lost.
	assign S_AXI_AWREADY = CE & ~aw_held_reg & ~bvalid_reg;
	assign S_AXI_WREADY  = CE & ~w_held_reg & ~bvalid_reg;
	assign S_AXI_ARREADY = CE & ~rvalid_reg;
	assign S_AXI_BVALID  = bvalid_reg;
	assign S_AXI_BRESP   = bresp_reg;
	assign S_AXI_RVALID  = rvalid_reg;
	assign S_AXI_RDATA   = rdata_reg;
	assign S_AXI_RRESP   = rresp_reg;

	genvar g;
	generate
		for (g = 0; g < NUM_BIDIR; g++) begin : g_port
			wire wr_data = do_write & wr_ok & w_lane0_reg & (wr_idx == IDX_DATA0 + 3'(g));
			wire wr_dir  = do_write & wr_ok & w_lane0_reg & (wr_idx == IDX_DIR0 + 3'(g));

			// The latch has no reset so that its contents survive one.
			always_ff @(posedge CORE_CLK) begin
				if (wr_data) begin
					latch_reg[g] <= w_data_reg; // RQ4 RQ5 RQ6
				end
			end

			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					dir_reg[g] <= DIR_RESET; // RQ3
				end else if (wr_dir) begin
					dir_reg[g] <= w_data_reg; // RQ1 RQ9
				end
			end

			// Input bits see the pin, output bits see the latch.
			assign rd_val[g] = (dir_reg[g] & latch_reg[g]) | (~dir_reg[g] & pin_in[g]); // RQ7 RQ8
		end
	endgenerate

	// Pins are driven only where the direction bit is one.
	assign P0_OUT = latch_reg[0];
	assign P0_OE  = dir_reg[0]; // RQ2 RQ10
	assign P1_OUT = latch_reg[1];
	assign P1_OE  = dir_reg[1]; // RQ2 RQ11
	assign P2_OUT = latch_reg[2];
	assign P2_OE  = dir_reg[2]; // RQ2 RQ12

	// The pullup comes with the interrupt option and only on inputs.
	assign P1_PULLUP = PULLUP_IRQ_OPT & ~dir_reg[1]; // RQ15

	// Serial drivers pass through, but never while reset is held.
	assign IN_OUT = SF_OUT;
	assign IN_OE  = RST ? '0 : SF_OE; // RQ13 RQ14

	// Optioned second port pins join the external line as a wired AND.
	assign irq_line_n = IRQ_N & (&(P1_IN | ~PULLUP_IRQ_OPT)); // RQ15 RQ16

	ext_irq_latch u_irq (
		.clk        (CORE_CLK),
		.rst        (RST),
		.ce         (CE),
		.line_n     (irq_line_n),
		.level_mode (EDGE_LEVEL_OPT), // RQ16
		.ack        (IRQ_ACK),
		.req        (IRQ_REQ)
	);

	always_comb begin
		case (rd_idx)
			IDX_DATA0:   rd_byte = rd_val[0];
			IDX_DATA1:   rd_byte = rd_val[1];
			IDX_DATA2:   rd_byte = rd_val[2];
			IDX_IN_DATA: rd_byte = in_val; // RQ20
			IDX_DIR0:    rd_byte = dir_reg[0]; // RQ9
			IDX_DIR1:    rd_byte = dir_reg[1];
			IDX_DIR2:    rd_byte = dir_reg[2];
			default:     rd_byte = 8'h00;
		endcase
	end

	// Write address and data are held separately and joined in order.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 8'h00;
			w_lane0_reg <= 1'b0;
		end else if (CE) begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (w_take) begin
				w_held_reg  <= 1'b1;
				w_data_reg  <= S_AXI_WDATA[7:0];
				w_lane0_reg <= S_AXI_WSTRB[0];
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Writes to the read-only input port are quietly accepted.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (CE) begin
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else if (CE) begin
			if (ar_take) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= {24'h000000, rd_ok ? rd_byte : 8'h00};
				rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	property p_dir_clear;
		@(posedge CORE_CLK)
		RST |-> (P0_OE == 8'h00 && P1_OE == 8'h00 && P2_OE == 8'h00);
	endproperty
	a_dir_clear: assert property (p_dir_clear) // RQ3
		else $error("Direction not cleared during reset.");

	property p_dir_write;
		@(posedge CORE_CLK) disable iff (RST)
		(do_write && wr_idx == IDX_DIR0 && w_lane0_reg) |=> P0_OE == $past(w_data_reg);
	endproperty
	a_dir_write: assert property (p_dir_write) // RQ2
		else $error("Direction write did not reach the enables.");

	property p_latch_write;
		@(posedge CORE_CLK) disable iff (RST)
		(do_write && wr_idx == IDX_DATA1 && w_lane0_reg) |=> P1_OUT == $past(w_data_reg);
	endproperty
	a_latch_write: assert property (p_latch_write) // RQ6
		else $error("Data write did not reach the second port latch.");

	property p_latch_only;
		@(posedge CORE_CLK) disable iff (RST)
		(do_write && wr_idx == IDX_DATA2 && dir_reg[2] == 8'h00) |=> P2_OE == 8'h00;
	endproperty
	a_latch_only: assert property (p_latch_only) // RQ5
		else $error("Data write to an input port drove a pin.");

	property p_read_mix;
		@(posedge CORE_CLK) disable iff (RST)
		(ar_take && rd_idx == IDX_DATA0)
		|=> S_AXI_RDATA[7:0] == (($past(P0_IN) & ~$past(P0_OE)) | ($past(P0_OUT) & $past(P0_OE)));
	endproperty
	a_read_mix: assert property (p_read_mix) // RQ7
		else $error("Port read mixed pin and latch wrongly.");

	property p_read_out;
		@(posedge CORE_CLK) disable iff (RST)
		(ar_take && rd_idx == IDX_DATA1 && P1_OE == 8'hFF) |=> S_AXI_RDATA[7:0] == $past(P1_OUT);
	endproperty
	a_read_out: assert property (p_read_out) // RQ8
		else $error("Output port read did not return the latch.");

	property p_read_dir;
		@(posedge CORE_CLK) disable iff (RST)
		(ar_take && rd_idx == IDX_DIR2) |=> S_AXI_RDATA == {24'h000000, $past(P2_OE)};
	endproperty
	a_read_dir: assert property (p_read_dir) // RQ9
		else $error("Direction read back wrong.");

	property p_read_in;
		@(posedge CORE_CLK) disable iff (RST)
		ar_take && rd_idx == IDX_IN_DATA |=> S_AXI_RDATA == {25'h0000000, $past(IN_PINS)};
	endproperty
	a_read_in: assert property (p_read_in) // RQ20
		else $error("Input port read wrong or top bit set.");

	property p_sf_off;
		@(posedge CORE_CLK) RST |-> IN_OE == 7'h00;
	endproperty
	a_sf_off: assert property (p_sf_off) // RQ14
		else $error("Special drivers on during reset.");

	property p_pullup;
		@(posedge CORE_CLK) disable iff (RST)
		$rose(P1_OE[0]) |-> !P1_PULLUP[0];
	endproperty
	a_pullup: assert property (p_pullup) // RQ15
		else $error("Pullup left on an output pin.");

	property p_bresp;
		@(posedge CORE_CLK) disable iff (RST)
		(aw_take && w_take) ##1 CE |=> S_AXI_BVALID;
	endproperty
	a_bresp: assert property (p_bresp) // RQ1
		else $error("Write response late.");

endmodule // gpio_ports

// ### verif/board_pins.sv
// Board side of one port: resolves each pin from the device and board drivers.
`timescale 1ns/100ps
module board_pins (
	// Clock.
	input  wire logic       clk,
	// Device side of the pins.
	input  wire logic [7:0] out_val,
	input  wire logic [7:0] oe,
	input  wire logic [7:0] pull_en,
	// Board drivers.
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	output logic [7:0]      level
);
	logic [7:0] last_reg;

	// A released pin with no pullup toggles, so a stale level never reads back.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (oe[i]) level[i] = out_val[i];
			else if (ext_en[i]) level[i] = ext_val[i];
			else if (pull_en[i]) level[i] = 1'b1;
			else level[i] = ~last_reg[i];
		end
	end

	always_ff @(posedge clk) last_reg <= level;
endmodule // board_pins

// ### verif/test_gpio_ports.sv
// Self-checking bench for the general purpose port block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module test_gpio_ports;
	import gpio_pkg::*;
	localparam logic [7:0] OPT = 8'h01;
	logic        clk = 0, rst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic        irq_n = 1, ack = 0;
	logic [3:0]  st = 4'hF;
	logic [4:0]  awa = '0, ara = '0;
	logic [31:0] wd = '0, seed = 32'h09DE58D4;
	logic [6:0]  inp = '0, sfo = '0, sfe = '0;
	logic [7:0]  ext [3], een [3], lat [3], dir [3];
	wire logic [7:0]  pout [3], poe [3], pin [3];
	wire logic [7:0]  pup;
	wire logic        awr, wr, bv, arr, rv, irq, irq_lvl;
	wire logic [1:0]  br, rr;
	wire logic [31:0] rdat;
	wire logic [6:0]  iout, ioe;
	int err_total = 0, check_count = 0;

	always #10 clk = ~clk;

	gpio_ports #(.PULLUP_IRQ_OPT(OPT), .EDGE_LEVEL_OPT(1'b0)) dut (
		.CORE_CLK(clk), .RST(rst), .CE(1'b1),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(st), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
		.S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
		.P0_IN(pin[0]), .P0_OUT(pout[0]), .P0_OE(poe[0]),
		.P1_IN(pin[1]), .P1_OUT(pout[1]), .P1_OE(poe[1]), .P1_PULLUP(pup),
		.P2_IN(pin[2]), .P2_OUT(pout[2]), .P2_OE(poe[2]),
		.IN_PINS(inp), .SF_OUT(sfo), .SF_OE(sfe), .IN_OUT(iout), .IN_OE(ioe),
		.IRQ_N(irq_n), .IRQ_ACK(ack), .IRQ_REQ(irq));

	// Same block in edge-and-level mode without the second port option; it shares the stimulus and only its request is compared.
	gpio_ports #(.PULLUP_IRQ_OPT(8'h00), .EDGE_LEVEL_OPT(1'b1)) dut_level (
		.CORE_CLK(clk), .RST(rst), .CE(1'b1),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(st), .S_AXI_WVALID(wv), .S_AXI_WREADY(),
		.S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bry),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(),
		.S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rry),
		.P0_IN(pin[0]), .P0_OUT(), .P0_OE(),
		.P1_IN(pin[1]), .P1_OUT(), .P1_OE(), .P1_PULLUP(),
		.P2_IN(pin[2]), .P2_OUT(), .P2_OE(),
		.IN_PINS(inp), .SF_OUT(sfo), .SF_OE(sfe), .IN_OUT(), .IN_OE(),
		.IRQ_N(irq_n), .IRQ_ACK(ack), .IRQ_REQ(irq_lvl));

	for (genvar g = 0; g < 3; g++) begin : g_pins
		board_pins u_pins (.clk(clk), .out_val(pout[g]), .oe(poe[g]),
			.pull_en(g == 1 ? pup : 8'h00), .ext_val(ext[g]), .ext_en(een[g]),
			.level(pin[g]));
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
	endfunction

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Handshakes are judged at the falling edge, where ready is settled.
	task automatic axw(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge clk);
		awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; bry <= 1;
		forever begin
			@(negedge clk);
			ta = awv & awr; tw = wv & wr; tb = bv & bry; r = br;
			@(posedge clk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			if (tb) begin bry <= 0; break; end
		end
	endtask

	task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge clk);
		ara <= a; arv <= 1; rry <= 1;
		forever begin
			@(negedge clk);
			ta = arv & arr; tr = rv & rry; d = rdat; r = rr;
			@(posedge clk);
			if (ta) arv <= 0;
			if (tr) begin rry <= 0; break; end
		end
	endtask

	task automatic chk_regs(input int p);
		logic [31:0] d;
		logic [1:0] r;
		axr(5'(4 * p), d, r);
		`CHK("data", {24'h0, (dir[p] & lat[p]) | (~dir[p] & pin[p])}, d)
		axr(5'(16 + 4 * p), d, r);
		`CHK("dir", {24'h0, dir[p]}, d)
		`CHK("rresp", RESP_OKAY, r)
	endtask

	task automatic wait_irq;
		for (int n = 0; n < 8 && irq !== 1'b1; n++) @(negedge clk);
		`CHK("irq", 1'b1, irq)
	endtask

	task automatic pulse_ack;
		@(posedge clk);
		ack <= 1;
		@(posedge clk);
		ack <= 0;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] v;
		int p;
		// Reset rises at time zero so the asynchronous branches see an edge.
		rst <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			ext[i] = 8'hFF;
			een[i] = (i == 1) ? ~OPT : 8'hFF;
			dir[i] = 8'h00;
		end
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++) chk_regs(i);
		$display("test reset values done");
		for (int k = 0; k < 24; k++) begin
			p = k % 3;
			seed = lfsr(seed);
			v = seed[7:0] | (p == 1 ? OPT : 8'h00);
			axw(5'(4 * p), v, r);
			lat[p] = v;
			`CHK("wresp", RESP_OKAY, r)
			axw(5'(16 + 4 * p), seed[15:8], r);
			dir[p] = seed[15:8];
			ext[p] <= seed[23:16] | (p == 1 ? OPT : 8'h00);
			@(negedge clk);
			`CHK("oe", dir[p], poe[p])
			`CHK("out", lat[p], pout[p])
			if (p == 1) `CHK("pullup", OPT & ~dir[1], pup)
			chk_regs(p);
		end
		st <= 4'hE;
		axw(5'h00, ~lat[0], r);
		st <= 4'hF;
		chk_regs(0);
		axw(5'h14, 8'hFF, r);
		dir[1] = 8'hFF;
		chk_regs(1);
		$display("test port traffic done");
		seed = lfsr(seed);
		inp <= seed[6:0]; sfo <= seed[13:7]; sfe <= seed[20:14];
		axr(5'h0C, d, r);
		`CHK("in port", {25'h0, inp}, d)
		axw(5'h0C, 8'hFF, r);
		`CHK("in port wresp", RESP_OKAY, r)
		`CHK("sf out", sfo, iout)
		`CHK("sf oe", sfe, ioe)
		axr(5'h1C, d, r);
		`CHK("unmapped rresp", RESP_SLVERR, r)
		`CHK("unmapped data", 32'h0, d)
		axw(5'h1C, 8'h5A, r);
		`CHK("unmapped wresp", RESP_SLVERR, r)
		$display("test input port done");
		sfe <= 7'h7F;
		rst <= 1'b1;
		@(negedge clk);
		`CHK("sf oe in reset", 7'h00, ioe)
		for (int i = 0; i < 3; i++) begin
			`CHK("oe in reset", 8'h00, poe[i])
			`CHK("latch kept", lat[i], pout[i])
			dir[i] = 8'h00;
		end
		@(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++) chk_regs(i);
		$display("test second reset done");
		@(negedge clk);
		`CHK("irq idle", 1'b0, irq)
		@(posedge clk);
		irq_n <= 1'b0;
		wait_irq;
		pulse_ack;
		`CHK("edge only", 1'b0, irq)
		`CHK("level held", 1'b1, irq_lvl)
		@(posedge clk);
		irq_n <= 1'b1;
		@(posedge clk);
		een[1] <= 8'hFF;
		ext[1] <= ~OPT;
		wait_irq;
		ext[1] <= 8'hFF;
		pulse_ack;
		`CHK("irq cleared", 1'b0, irq)
		`CHK("level cleared", 1'b0, irq_lvl)
		$display("test interrupt done");
		stop_test;
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		stop_test;
	end
endmodule // test_gpio_ports
